// file: hdl/ifb_defines.svh
// Constants of the instruction format and byte order block.
// Assumes inclusion by the top module and the testbench only.
`ifndef IFB_DEFINES_SVH
`define IFB_DEFINES_SVH

// Special register numbers; the APB byte address is four times these.
`define IFB_IDX_PROG_CNT 16'h0000
`define IFB_IDX_MSTAT 16'h0001
`define IFB_IDX_EXC_ADDR 16'h0003
`define IFB_IDX_EXC_CAUSE 16'h0005
`define IFB_IDX_FSTAT 16'h0007
`define IFB_IDX_BR_TARGET 16'h000b
`define IFB_IDX_VER_BASE 16'h2000
`define IFB_IDX_CTRL 16'h0040
`define IFB_IDX_STAT 16'h0041

// Bit labelled 29 counts from the MSB, so it is numeric bit 2.
`define IFB_MSTAT_CARRY_BIT 2

// Control bits and reset values.
`define IFB_CTRL_DEC_EN 0
`define IFB_CTRL_PFX_EN 1
`define IFB_CTRL_RST 32'h0000_0003
`define IFB_MSTAT_RST 32'h0000_0000
`define IFB_FSTAT_RST 32'h0000_0000

// Opcodes with a fixed meaning here.
`define IFB_OP_PREFIX 6'h2c
`define IFB_OP_STREAM 6'h1b
`define IFB_OP_SPECIAL 6'h25
`define IFB_TYPEB_BIT 3

// Byte lane masks.
`define IFB_LANES_ALL 4'hf
`define IFB_LANES_LO 4'h3
`define IFB_LANES_HI 4'hc
`define IFB_LANES_ONE 4'h1

`endif

// file: hdl/ifb_pkg.sv
// Types of the instruction format and byte order block.
// Assumes the constants header sits beside it.
package ifb_pkg;

    // Decoder states, one-hot.
    typedef enum logic [1:0] {
        IFB_ST_IDLE = 2'b01,
        IFB_ST_PFX = 2'b10
    } ifb_state_e;

    // Access sizes, one-hot.
    typedef enum logic [2:0] {
        IFB_SZ_BYTE = 3'b001,
        IFB_SZ_HALF = 3'b010,
        IFB_SZ_WORD = 3'b100
    } ifb_size_e;

    // Functional groups, one-hot.
    typedef enum logic [4:0] {
        IFB_GRP_ARITH = 5'b00001,
        IFB_GRP_LOGIC = 5'b00010,
        IFB_GRP_BRANCH = 5'b00100,
        IFB_GRP_LDST = 5'b01000,
        IFB_GRP_SPECIAL = 5'b10000
    } ifb_grp_e;

    // Decoded instruction.
    typedef struct packed {
        logic valid;
        logic type_b;
        logic prefixed;
        ifb_grp_e group;
        logic [5:0] opcode;
        logic [4:0] dest;
        logic [4:0] source_a;
        logic [4:0] source_b;
        logic [31:0] imm;
        logic [3:0] stream_port_selector;
        logic [13:0] special_register;
    } ifb_dec_s;

    // Core state shown through the special registers.
    typedef struct packed {
        logic [31:0] program_counter;
        logic [31:0] exception_address;
        logic [31:0] exception_cause;
        logic [31:0] branch_target;
    } ifb_core_s;

    // Load/store request from the execute stage.
    typedef struct packed {
        logic valid;
        logic store;
        logic reversed;
        ifb_size_e size;
        logic [1:0] addr;
        logic [31:0] wdata;
        logic [31:0] bus_rdata;
    } ifb_ls_req_s;

    // Steered load/store answer.
    typedef struct packed {
        logic valid;
        logic misaligned;
        logic [3:0] lanes;
        logic [31:0] wdata;
        logic [31:0] rdata;
    } ifb_ls_rsp_s;

endpackage : ifb_pkg

// file: hdl/ifb_top.sv
// Instruction decoder, special register file and byte steering.
// Assumes one 50 MHz clock, an APB master and synchronous inputs.
`timescale 1ns/1ps
`include "ifb_defines.svh"

// Contract
// - Byte order is big or little endian, fixed by a build parameter.
// - Load/store supports word, half word and byte sizes only.
// - Reversed half and word loads and stores swap byte order.
// - Big endian puts MS byte at n; little at n+3; bit 0 is MSB.
// - Every instruction is a 32-bit word of type A or type B.
// - Type A yields two source selectors and one destination.
// - Type B yields one source, one destination, 16-bit immediate.
// - Type B after the prefix instruction gets a 32-bit immediate.
// - Each register selector addresses one of registers 0 to 31.
// - Instructions fall in five groups: arith, logic, branch, ldst, special.
// - Machine status is special register 1, carry in its bit 29.
// - Exception cause is special register 5, address is 3.
// - Float unit status is special register 7.
// - Branch target is special register 11.
// - Special register 0 returns the execute stage program counter.
// - Version word x is special register 8192 plus x.
// - Stream instructions carry a 4-bit stream port selector.
// - Memory accesses must be aligned to the data size.
module ifb_top #(
    parameter bit BIG_ENDIAN = 1'b1,
    parameter int NUM_VER = 2,
    // Arbitrary version contents.
    parameter logic [NUM_VER*32-1:0] VER_WORDS = '0
) (
    // Clock and reset.
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    // APB slave.
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [17:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic O_PREADY,
    output logic [31:0] O_PRDATA,
    output logic O_PSLVERR,
    // Fetch side.
    input wire logic I_INSTR_VALID,
    input wire logic [31:0] I_INSTR,
    output ifb_pkg::ifb_dec_s O_DEC,
    // Core state and load/store path.
    input wire ifb_pkg::ifb_core_s I_CORE,
    input wire ifb_pkg::ifb_ls_req_s I_LS_REQ,
    output ifb_pkg::ifb_ls_rsp_s O_LS,
    // Status registers kept here.
    output logic [31:0] O_MACHINE_STATUS,
    output logic [31:0] O_FLOAT_UNIT_STATUS
);
    import ifb_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        ifb_state_e st;
        logic [15:0] pfx;
        ifb_dec_s dec;
        ifb_ls_rsp_s ls;
        logic [31:0] mstat;
        logic [31:0] fstat;
        logic [31:0] ctrl;
        logic mis_seen;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ifb_regs_s;

    ifb_regs_s r;
    ifb_regs_s r_nxt;
    logic rst_meta_r;
    logic rst_n;

    // ----------------------------------------
    // Functions
    // ----------------------------------------

    // Reverses the four bytes of a word.
    function automatic logic [31:0] ifb_swap32(input logic [31:0] d);
        ifb_swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction : ifb_swap32

    // Reverses the two bytes of a half word.
    function automatic logic [15:0] ifb_swap16(input logic [15:0] d);
        ifb_swap16 = {d[7:0], d[15:8]};
    endfunction : ifb_swap16

    // Sorts an opcode into one of the five groups.
    function automatic ifb_grp_e ifb_group(input logic [5:0] op);
        if (op == `IFB_OP_STREAM || op == `IFB_OP_PREFIX || op == `IFB_OP_SPECIAL) begin
            ifb_group = IFB_GRP_SPECIAL;
        end else if (!op[5]) begin
            ifb_group = IFB_GRP_ARITH;
        end else if (op[5:4] == 2'h3) begin
            ifb_group = IFB_GRP_LDST;
        end else if (op[2:1] == 2'h3 || op == 6'h2d) begin
            ifb_group = IFB_GRP_BRANCH;
        end else begin
            ifb_group = IFB_GRP_LOGIC;
        end
    endfunction : ifb_group

    // ----------------------------------------
    // Reset release
    // ----------------------------------------

    // Two flops so that every register leaves reset on the same edge.
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic [5:0] op;
    logic [15:0] idx;
    logic [15:0] vi;
    logic eb;
    logic [15:0] half;
    logic [15:0] pick;
    logic dec_en;
    logic pfx_en;

    assign op = I_INSTR[31:26];
    assign idx = I_PADDR[17:2];
    assign vi = idx - `IFB_IDX_VER_BASE;
    assign dec_en = r.ctrl[`IFB_CTRL_DEC_EN];
    assign pfx_en = r.ctrl[`IFB_CTRL_PFX_EN];
    // Reversed forms flip the build-time order for the access.
    assign eb = BIG_ENDIAN ^ I_LS_REQ.reversed;

    // Decode, steering and the APB register file in one pass.
    always_comb begin
        r_nxt = r;
        half = '0;
        pick = '0;
        r_nxt.dec.valid = 1'b0;

        // Each instruction is one fixed word of type A or B.
        if (I_INSTR_VALID && dec_en) begin
            r_nxt.dec.valid = 1'b1;
            r_nxt.dec.opcode = op;
            r_nxt.dec.type_b = op[`IFB_TYPEB_BIT];
            r_nxt.dec.group = ifb_group(op);
            // Five-bit fields reach all 32 registers.
            r_nxt.dec.dest = I_INSTR[25:21];
            r_nxt.dec.source_a = I_INSTR[20:16];
            r_nxt.dec.source_b = op[`IFB_TYPEB_BIT] ? 5'h00 : I_INSTR[15:11];
            r_nxt.dec.stream_port_selector = I_INSTR[3:0];
            r_nxt.dec.special_register = I_INSTR[13:0];
            // The prefix widens only the next instruction.
            if (r.st == IFB_ST_PFX) begin
                r_nxt.dec.imm = {r.pfx, I_INSTR[15:0]};
                r_nxt.dec.prefixed = 1'b1;
            end else begin
                r_nxt.dec.imm = {{16{I_INSTR[15]}}, I_INSTR[15:0]};
                r_nxt.dec.prefixed = 1'b0;
            end
            if (op == `IFB_OP_PREFIX && pfx_en) begin
                r_nxt.st = IFB_ST_PFX;
                r_nxt.pfx = I_INSTR[15:0];
            end else begin
                r_nxt.st = IFB_ST_IDLE;
            end
        end

        // Load/store lanes; a misaligned access drives no lane.
        r_nxt.ls = '0;
        if (I_LS_REQ.valid) begin
            r_nxt.ls.valid = 1'b1;
            case (I_LS_REQ.size)
                IFB_SZ_WORD: begin
                    r_nxt.ls.misaligned = |I_LS_REQ.addr;
                    r_nxt.ls.lanes = `IFB_LANES_ALL;
                    r_nxt.ls.wdata = eb ? ifb_swap32(I_LS_REQ.wdata) : I_LS_REQ.wdata;
                    r_nxt.ls.rdata = eb ? ifb_swap32(I_LS_REQ.bus_rdata) : I_LS_REQ.bus_rdata;
                end
                IFB_SZ_HALF: begin
                    r_nxt.ls.misaligned = I_LS_REQ.addr[0];
                    r_nxt.ls.lanes = I_LS_REQ.addr[1] ? `IFB_LANES_HI : `IFB_LANES_LO;
                    half = eb ? ifb_swap16(I_LS_REQ.wdata[15:0]) : I_LS_REQ.wdata[15:0];
                    r_nxt.ls.wdata = {half, half};
                    pick = I_LS_REQ.addr[1] ? I_LS_REQ.bus_rdata[31:16] : I_LS_REQ.bus_rdata[15:0];
                    r_nxt.ls.rdata = {16'h0000, eb ? ifb_swap16(pick) : pick};
                end
                default: begin
                    // A single byte has no order to reverse.
                    r_nxt.ls.lanes = `IFB_LANES_ONE << I_LS_REQ.addr;
                    r_nxt.ls.wdata = {4{I_LS_REQ.wdata[7:0]}};
                    r_nxt.ls.rdata = {24'h000000, I_LS_REQ.bus_rdata[{I_LS_REQ.addr, 3'h0} +: 8]};
                end
            endcase
            if (r_nxt.ls.misaligned) begin
                r_nxt.ls.lanes = 4'h0;
                r_nxt.mis_seen = 1'b1;
            end
        end

        // Setup phase prepares the answer; it is ready one cycle later.
        if (I_PSEL && !I_PENABLE) begin
            r_nxt.pready = 1'b1;
            r_nxt.pslverr = 1'b0;
            r_nxt.prdata = '0;
            if (idx == `IFB_IDX_PROG_CNT) begin
                r_nxt.prdata = I_CORE.program_counter;
                r_nxt.pslverr = I_PWRITE;
            end else if (idx == `IFB_IDX_MSTAT) begin
                r_nxt.prdata = r.mstat;
            end else if (idx == `IFB_IDX_EXC_ADDR) begin
                r_nxt.prdata = I_CORE.exception_address;
                r_nxt.pslverr = I_PWRITE;
            end else if (idx == `IFB_IDX_EXC_CAUSE) begin
                r_nxt.prdata = I_CORE.exception_cause;
                r_nxt.pslverr = I_PWRITE;
            end else if (idx == `IFB_IDX_FSTAT) begin
                r_nxt.prdata = r.fstat;
            end else if (idx == `IFB_IDX_BR_TARGET) begin
                r_nxt.prdata = I_CORE.branch_target;
                r_nxt.pslverr = I_PWRITE;
            end else if (idx == `IFB_IDX_CTRL) begin
                r_nxt.prdata = r.ctrl;
            end else if (idx == `IFB_IDX_STAT) begin
                // The sticky flag is cleared only when the write completes.
                r_nxt.prdata = {29'h0, r.mis_seen, r.st == IFB_ST_PFX, 1'b0};
            end else if (idx >= `IFB_IDX_VER_BASE && vi < 16'(NUM_VER)) begin
                r_nxt.prdata = VER_WORDS[vi*32 +: 32];
                r_nxt.pslverr = I_PWRITE;
            end else begin
                r_nxt.pslverr = 1'b1;
            end
        end else begin
            r_nxt.pready = 1'b0;
        end

        // Writes land only at the completing edge of the access phase.
        if (I_PSEL && I_PENABLE && r.pready && I_PWRITE && !r.pslverr) begin
            if (idx == `IFB_IDX_MSTAT) begin
                r_nxt.mstat = I_PWDATA;
            end else if (idx == `IFB_IDX_FSTAT) begin
                r_nxt.fstat = I_PWDATA;
            end else if (idx == `IFB_IDX_CTRL) begin
                r_nxt.ctrl = I_PWDATA;
                if (!I_PWDATA[`IFB_CTRL_PFX_EN]) begin
                    r_nxt.st = IFB_ST_IDLE;
                end
            end else if (idx == `IFB_IDX_STAT) begin
                // A misalignment in this same cycle wins over the clear.
                r_nxt.mis_seen = r_nxt.ls.misaligned;
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------

    // All state moves on one edge.
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= IFB_ST_IDLE;
            r.mstat <= `IFB_MSTAT_RST;
            r.fstat <= `IFB_FSTAT_RST;
            r.ctrl <= `IFB_CTRL_RST;
        end else begin
            r <= r_nxt;
        end
    end

    // Outputs straight from the state flops.
    assign O_DEC = r.dec;
    assign O_LS = r.ls;
    assign O_PREADY = r.pready;
    assign O_PRDATA = r.prdata;
    assign O_PSLVERR = r.pslverr;
    assign O_MACHINE_STATUS = r.mstat;
    assign O_FLOAT_UNIT_STATUS = r.fstat;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!rst_n);

    logic is_pfx;
    assign is_pfx = I_INSTR_VALID && op == `IFB_OP_PREFIX && dec_en && pfx_en;

    sequence s_prefix;
        is_pfx;
    endsequence

    sequence s_follow;
        I_INSTR_VALID && dec_en && op != `IFB_OP_PREFIX;
    endsequence

    sequence s_status_write;
        I_PSEL && !I_PENABLE && I_PWRITE && idx == `IFB_IDX_MSTAT;
    endsequence

    chk_word_lane_order: assert property (
        I_LS_REQ.valid && I_LS_REQ.size == IFB_SZ_WORD && I_LS_REQ.addr == 2'h0
        |=> O_LS.wdata[7:0] == $past(eb ? I_LS_REQ.wdata[31:24] : I_LS_REQ.wdata[7:0]))
        else $error("word lane order wrong");

    chk_half_lanes: assert property (
        I_LS_REQ.valid && I_LS_REQ.size == IFB_SZ_HALF && !I_LS_REQ.addr[0]
        |=> O_LS.lanes == ($past(I_LS_REQ.addr[1]) ? `IFB_LANES_HI : `IFB_LANES_LO))
        else $error("half word lanes wrong");

    chk_misalign_blocks: assert property (
        I_LS_REQ.valid && I_LS_REQ.size == IFB_SZ_WORD && I_LS_REQ.addr != 2'h0
        |=> O_LS.misaligned && O_LS.lanes == 4'h0)
        else $error("misaligned word not blocked");

    chk_prefix_imm: assert property (
        s_prefix ##1 s_follow |=> O_DEC.prefixed && O_DEC.imm[31:16] == $past(I_INSTR[15:0], 2))
        else $error("prefix not joined to immediate");

    chk_sign_extend: assert property (
        I_INSTR_VALID && dec_en && r.st == IFB_ST_IDLE
        |=> !O_DEC.prefixed && O_DEC.imm == {{16{$past(I_INSTR[15])}}, $past(I_INSTR[15:0])})
        else $error("immediate not sign extended");

    chk_operand_fields: assert property (
        I_INSTR_VALID && dec_en
        |=> O_DEC.valid && O_DEC.dest == $past(I_INSTR[25:21]) && O_DEC.source_a == $past(I_INSTR[20:16]))
        else $error("operand selectors wrong");

    chk_group_onehot: assert property (
        O_DEC.valid |-> $onehot(O_DEC.group))
        else $error("group not one-hot");

    chk_status_write: assert property (
        s_status_write |=> O_PREADY ##1 O_MACHINE_STATUS == $past(I_PWDATA, 2))
        else $error("machine status write lost");

    chk_stream_port: assert property (
        I_INSTR_VALID && dec_en && op == `IFB_OP_STREAM
        |=> O_DEC.stream_port_selector == $past(I_INSTR[3:0]))
        else $error("stream port selector wrong");

    chk_counter_read: assert property (
        I_PSEL && !I_PENABLE && !I_PWRITE && idx == `IFB_IDX_PROG_CNT
        |=> O_PREADY && O_PRDATA == $past(I_CORE.program_counter))
        else $error("program counter read wrong");

    // The sticky flag must survive a clear that lands with a new misalignment.
    chk_sticky_set_wins: assert property (
        I_LS_REQ.valid && I_LS_REQ.size == IFB_SZ_WORD && I_LS_REQ.addr != 2'h0
        |=> r.mis_seen)
        else $error("misalignment flag not kept");

    // Read-only registers refuse writes in the answer cycle.
    chk_readonly_refused: assert property (
        I_PSEL && !I_PENABLE && I_PWRITE && idx == `IFB_IDX_PROG_CNT
        |=> O_PREADY && O_PSLVERR)
        else $error("read-only write not refused");

endmodule : ifb_top

// file: tb/ifb_top_test.sv
// Self-checking bench for the decoder, special registers and byte steering.
// Assumes the design files in hdl/ and the constants header on the include path.
`timescale 1ns/1ps
`include "ifb_defines.svh"
module ifb_top_test;
    import ifb_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic instr_valid = 1'b0;
    logic [31:0] instr = 32'h0;
    ifb_dec_s dec;
    ifb_dec_s dq;
    ifb_core_s core = {32'h0000_1000, 32'h0000_2000, 32'h0000_3000, 32'h0000_4000};
    ifb_ls_req_s ls_req = '0;
    ifb_ls_rsp_s ls;
    logic [31:0] mstat;
    logic [31:0] fstat;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int tests_run = 0;

    // Version words are arbitrary test values.
    ifb_top #(.BIG_ENDIAN(1'b1), .NUM_VER(2), .VER_WORDS(64'h0000_00b2_0000_00b1)) ifb_top_inst (
        .I_CLOCK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr),
        .I_INSTR_VALID(instr_valid), .I_INSTR(instr), .O_DEC(dec), .I_CORE(core), .I_LS_REQ(ls_req),
        .O_LS(ls), .O_MACHINE_STATUS(mstat), .O_FLOAT_UNIT_STATUS(fstat)
    );

    // Clock of 50 MHz.
    always #10 clk = ~clk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the verdict and ends the run.
    task automatic conclude();
        $display("errors %0d, comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // One APB transfer; pready and the answer are taken at the rising edge, before the design updates.
    task automatic apb(input bit wr, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            check(32'h0, 32'h1);
        end
    endtask : apb

    // Reads a register and checks the error response, and the data when no error is expected.
    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input logic experr);
        apb(1'b0, idx, 32'h0);
        check(32'(err), 32'(experr));
        if (!experr) begin
            check(rd, exp);
        end
    endtask : rd_chk

    // Writes a register and checks the error response.
    task automatic wr_chk(input logic [15:0] idx, input logic [31:0] wd, input logic experr);
        apb(1'b1, idx, wd);
        check(32'(err), 32'(experr));
    endtask : wr_chk

    // Presents one instruction word and captures the decode if it comes.
    task automatic dec_op(input logic [31:0] w, input logic exp_v);
        int n;
        logic got;
        got = 1'b0;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= w;
        @(posedge clk);
        instr_valid <= 1'b0;
        instr <= ~w;
        for (n = 0; n < 4; n++) begin
            #1;
            if (dec.valid === 1'b1) begin
                dq = dec;
                got = 1'b1;
                break;
            end
            @(posedge clk);
        end
        check(32'(got), 32'(exp_v));
    endtask : dec_op

    // One load or store through the steering path.
    task automatic ls_op(input logic st, input logic rev, input ifb_size_e sz, input logic [1:0] a,
                         input logic [31:0] d, input logic [3:0] el, input logic [31:0] ed, input logic em);
        int n;
        n = 0;
        @(posedge clk);
        ls_req <= '{valid: 1'b1, store: st, reversed: rev, size: sz, addr: a, wdata: d, bus_rdata: d};
        @(posedge clk);
        ls_req <= '0;
        #1;
        while (ls.valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(32'(ls.valid), 32'h1);
        check(32'(ls.misaligned), 32'(em));
        check(32'(ls.lanes), 32'(el));
        if (!em) begin
            check(st ? ls.wdata : ls.rdata, ed);
        end
    endtask : ls_op

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    initial begin
        #200000;
        num_errors++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        // Map and reset values of the special registers.
        rd_chk(16'h0000, 32'h0000_1000, 1'b0);
        rd_chk(16'h0003, 32'h0000_2000, 1'b0);
        rd_chk(16'h0005, 32'h0000_3000, 1'b0);
        rd_chk(16'h000b, 32'h0000_4000, 1'b0);
        rd_chk(16'h0001, 32'h0000_0000, 1'b0);
        rd_chk(16'h0007, 32'h0000_0000, 1'b0);
        rd_chk(16'h0040, 32'h0000_0003, 1'b0);
        rd_chk(16'h2000, 32'h0000_00b1, 1'b0);
        rd_chk(16'h2001, 32'h0000_00b2, 1'b0);
        rd_chk(16'h2002, 32'h0, 1'b1);
        rd_chk(16'h0002, 32'h0, 1'b1);
        // Writable and read-only registers; carry sits at numeric bit 2.
        wr_chk(16'h0001, 32'h2000_0004, 1'b0);
        @(posedge clk);
        check(32'(mstat[`IFB_MSTAT_CARRY_BIT]), 32'h1);
        rd_chk(16'h0001, 32'h2000_0004, 1'b0);
        wr_chk(16'h0007, 32'h5a5a_0001, 1'b0);
        @(posedge clk);
        check(fstat, 32'h5a5a_0001);
        rd_chk(16'h0007, 32'h5a5a_0001, 1'b0);
        wr_chk(16'h0000, 32'hffff_ffff, 1'b1);
        rd_chk(16'h0000, 32'h0000_1000, 1'b0);
        wr_chk(16'h0002, 32'hffff_ffff, 1'b1);
        // Register-register word with boundary selectors.
        dec_op({6'h00, 5'd31, 5'd1, 5'd30, 11'h0}, 1'b1);
        check({dq.type_b, dq.dest, dq.source_a, dq.source_b}, {16'h0, 1'b0, 5'd31, 5'd1, 5'd30});
        check(32'(dq.group), 32'(IFB_GRP_ARITH));
        // Register-immediate word without prefix is sign-extended.
        dec_op({6'h08, 5'd2, 5'd3, 16'h8001}, 1'b1);
        check({dq.type_b, dq.prefixed, dq.dest, dq.source_a, dq.source_b}, {15'h0, 2'b10, 5'd2, 5'd3, 5'd0});
        check(dq.imm, 32'hffff_8001);
        // Prefix, an idle gap, then the widened immediate.
        dec_op({6'h2c, 10'h0, 16'h1234}, 1'b1);
        check(32'(dq.group), 32'(IFB_GRP_SPECIAL));
        apb(1'b0, 16'h0041, 32'h0);
        check(32'(rd[1]), 32'h1);
        dec_op({6'h08, 5'd4, 5'd5, 16'h8001}, 1'b1);
        check({31'h0, dq.prefixed}, 32'h1);
        check(dq.imm, 32'h1234_8001);
        dec_op({6'h0c, 5'd6, 5'd7, 16'h7fff}, 1'b1);
        check({dq.prefixed, dq.imm[30:0]}, 32'h0000_7fff);
        // Prefix and its follower back to back, with no idle cycle.
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= {6'h2c, 10'h0, 16'hbeef};
        @(posedge clk);
        instr <= {6'h08, 5'd1, 5'd2, 16'h0001};
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        check(32'(dec.prefixed), 32'h1);
        check(dec.imm, 32'hbeef_0001);
        // Remaining groups and the special and stream fields.
        dec_op({6'h21, 26'h0}, 1'b1);
        check(32'(dq.group), 32'(IFB_GRP_LOGIC));
        dec_op({6'h2d, 26'h0}, 1'b1);
        check(32'(dq.group), 32'(IFB_GRP_BRANCH));
        dec_op({6'h30, 26'h0}, 1'b1);
        check(32'(dq.group), 32'(IFB_GRP_LDST));
        dec_op({6'h25, 12'h0, 14'h2001}, 1'b1);
        check(32'(dq.special_register), 32'h2001);
        dec_op({6'h1b, 22'h0, 4'ha}, 1'b1);
        check(32'(dq.stream_port_selector), 32'ha);
        // Decoding switched off takes no word.
        wr_chk(16'h0040, 32'h0, 1'b0);
        dec_op({6'h00, 26'h1}, 1'b0);
        wr_chk(16'h0040, 32'h3, 1'b0);
        // Steering under big-endian order, plain and reversed.
        ls_op(1, 0, IFB_SZ_WORD, 2'd0, 32'h1122_3344, 4'hf, 32'h4433_2211, 0);
        ls_op(1, 1, IFB_SZ_WORD, 2'd0, 32'h1122_3344, 4'hf, 32'h1122_3344, 0);
        ls_op(1, 0, IFB_SZ_HALF, 2'd0, 32'h1122_3344, 4'h3, 32'h4433_4433, 0);
        ls_op(1, 1, IFB_SZ_HALF, 2'd2, 32'h1122_3344, 4'hc, 32'h3344_3344, 0);
        ls_op(1, 0, IFB_SZ_BYTE, 2'd3, 32'h1122_3344, 4'h8, 32'h4444_4444, 0);
        ls_op(1, 1, IFB_SZ_BYTE, 2'd1, 32'h1122_3344, 4'h2, 32'h4444_4444, 0);
        ls_op(0, 0, IFB_SZ_WORD, 2'd0, 32'h4433_2211, 4'hf, 32'h1122_3344, 0);
        ls_op(0, 0, IFB_SZ_HALF, 2'd2, 32'haabb_ccdd, 4'hc, 32'h0000_bbaa, 0);
        ls_op(0, 1, IFB_SZ_HALF, 2'd2, 32'haabb_ccdd, 4'hc, 32'h0000_aabb, 0);
        ls_op(0, 0, IFB_SZ_BYTE, 2'd2, 32'haabb_ccdd, 4'h4, 32'h0000_00bb, 0);
        // Misaligned accesses are flagged and remembered.
        ls_op(1, 0, IFB_SZ_WORD, 2'd1, 32'h1122_3344, 4'h0, 32'h0, 1);
        ls_op(0, 0, IFB_SZ_HALF, 2'd3, 32'h1122_3344, 4'h0, 32'h0, 1);
        apb(1'b0, 16'h0041, 32'h0);
        check(32'(rd[2]), 32'h1);
        conclude();
    end
endmodule : ifb_top_test
